// ---- rtl/usb_clock_reset_wrapper_ctrl.sv ----
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module usb_clock_reset_wrapper_ctrl
  import usb_wrapper_pkg::*;
(
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               srst,
  // register port
  input  wire logic [usb_wrapper_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [usb_wrapper_pkg::DATA_W-1:0] regWrData,
  input  wire logic                               regWrite,
  input  wire logic                               regRead,
  output logic      [usb_wrapper_pkg::DATA_W-1:0] regRdData,
  // interrupt
  output logic                                    irq,
  // from the otg controller core
  input  wire logic                               otgBusEvent,
  input  wire logic                               otgResumeDetect,
  input  wire logic                               otgSuspended,
  input  wire logic                               otgBusActivity,
  // from the phy and its comparators
  input  wire logic                               phyId,
  input  wire logic                               phyVbusValid,
  input  wire logic                               phyASessionValid,
  input  wire logic                               phyBSessionValid,
  input  wire logic                               phySessionEnd,
  // towards the otg controller core
  output logic                                    otgId,
  output logic                                    otgVbusValid,
  output logic                                    otgASessionValid,
  output logic                                    otgBSessionValid,
  output logic                                    otgSessionEnd
);
  import usb_wrapper_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] syncFirst;
    logic [SYNC_W-1:0] syncSecond;
    logic [CTRL_W-1:0] ctrl;
    logic              generalEventFlag;
    logic              resumeFlag;
    logic              activityStatus;
    logic [DATA_W-1:0] rdData;
    logic              idOut;
    logic              vbusOut;
    logic              aSessOut;
    logic              bSessOut;
    logic              sessEndOut;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [SYNC_W-1:0] rawIn;
  logic              hit;
  logic              wrHit;
  logic              rdHit;
  logic [DATA_W-1:0] wordView;

  assign rawIn = {phySessionEnd, phyBSessionValid, phyASessionValid,
                  phyVbusValid, phyId, otgBusActivity, otgSuspended,
                  otgResumeDetect, otgBusEvent};

  assign hit   = (regAddr == CTRL_STATUS_ADDR);
  assign wrHit = regWrite && hit;
  assign rdHit = regRead && hit;

  // assembled read view; unlisted bits stay zero
  always_comb
  begin
    wordView = '0;
    wordView[GENERAL_EVENT_FLAG_BIT] = state_reg.generalEventFlag;
    wordView[RESUME_FLAG_BIT]        = state_reg.resumeFlag;
    wordView[ACTIVITY_STATUS_BIT]    = state_reg.activityStatus;
    wordView[RESERVED_ONE_BIT]       = 1'b1;
    wordView[CTRL_W-1:0]             = state_reg.ctrl;
  end

  always_comb
  begin
    state_next = state_reg;

    // second stage alone reads the first
    state_next.syncFirst  = rawIn;
    state_next.syncSecond = state_reg.syncFirst;

    // only the control field is writable; a one in the activity status bit clears it, all else ignores writes
    if (wrHit)
    begin
      state_next.ctrl = regWrData[CTRL_W-1:0];
    end

    // controller owns set and clear; reads zero while its enable is off
    state_next.generalEventFlag = state_reg.syncSecond[S_OTG_EVENT]
      && state_reg.ctrl[GENERAL_EVENT_IRQ_BIT];

    // resume only counts while the link is suspended
    state_next.resumeFlag = state_reg.syncSecond[S_RESUME_DET]
                            && state_reg.syncSecond[S_SUSPENDED];

    // write one clears; a same-cycle activity still wins
    if (wrHit && regWrData[ACTIVITY_STATUS_BIT])
    begin
      state_next.activityStatus = 1'b0;
    end
    if (state_reg.syncSecond[S_ACTIVITY])
    begin
      state_next.activityStatus = 1'b1;
    end

    // read data valid in the following cycle only
    if (rdHit)
    begin
      state_next.rdData = wordView;
    end
    else
    begin
      state_next.rdData = '0;
    end

    // id source select; override wins, else disabled monitoring forces the default level
    if (state_reg.ctrl[ID_OVERRIDE_ENABLE_BIT])
    begin
      state_next.idOut = state_reg.ctrl[ID_OVERRIDE_VALUE_BIT];
    end
    else if (state_reg.ctrl[PHY_ID_MONITOR_BIT])
    begin
      state_next.idOut = state_reg.syncSecond[S_PHY_ID];
    end
    else
    begin
      state_next.idOut = ID_DEFAULT_LEVEL;
    end

    // comparators are gated low while their monitor is off
    state_next.vbusOut = state_reg.syncSecond[S_VBUS_VALID]
                         && state_reg.ctrl[VBUS_VALID_MONITOR_BIT];
    state_next.aSessOut = state_reg.syncSecond[S_A_SESSION]
                          && state_reg.ctrl[A_SESSION_MONITOR_BIT];
    state_next.bSessOut = state_reg.syncSecond[S_B_SESSION]
                          && state_reg.ctrl[B_SESSION_MONITOR_BIT];
    state_next.sessEndOut = state_reg.syncSecond[S_SESSION_END]
      && state_reg.ctrl[SESSION_END_MONITOR_BIT];

    if (srst)
    begin
      state_next.syncFirst        = SYNC_RESET;
      state_next.syncSecond       = SYNC_RESET;
      state_next.ctrl             = CTRL_RESET;
      state_next.generalEventFlag = GENERAL_EVENT_RESET;
      state_next.resumeFlag       = RESUME_RESET;
      state_next.activityStatus   = ACTIVITY_RESET;
      state_next.rdData           = '0;
      state_next.idOut            = ID_DEFAULT_LEVEL;
      state_next.vbusOut          = 1'b0;
      state_next.aSessOut         = 1'b0;
      state_next.bSessOut         = 1'b0;
      state_next.sessEndOut       = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  assign regRdData        = state_reg.rdData;
  assign otgId            = state_reg.idOut;
  assign otgVbusValid     = state_reg.vbusOut;
  assign otgASessionValid = state_reg.aSessOut;
  assign otgBSessionValid = state_reg.bSessOut;
  assign otgSessionEnd    = state_reg.sessEndOut;

  // each flag gated by its own enable; level, not pulse
  assign irq = (state_reg.generalEventFlag
                && state_reg.ctrl[GENERAL_EVENT_IRQ_BIT])
            || (state_reg.resumeFlag && state_reg.ctrl[RESUME_IRQ_BIT])
            || (state_reg.activityStatus
                && state_reg.ctrl[ACTIVITY_IRQ_BIT]);

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence readCycle;
    rdHit;
  endsequence

  sequence activityClearWrite;
    wrHit && regWrData[ACTIVITY_STATUS_BIT]
      && !state_reg.syncSecond[S_ACTIVITY];
  endsequence

  sequence resumeSeen;
    otgResumeDetect && otgSuspended;
  endsequence

  property reservedBitsFixed;
    readCycle |=> (regRdData[RESERVED_ONE_BIT] == 1'b1)
                  && ((regRdData & ~IMPLEMENTED_MASK) == '0);
  endproperty

  chk_reserved_read_one: assert property (reservedBitsFixed)
    else $error("reserved bits read wrongly");

  chk_unimpl_read_zero: assert property (
    wrHit ##1 rdHit |=> (regRdData[31:27] == 5'h00)
                        && (regRdData[23:16] == 8'h00)
                        && (regRdData[14:10] == 5'h00))
    else $error("unimplemented bits not zero");

  chk_idle_read_zero: assert property (
    !rdHit |=> regRdData == '0)
    else $error("read data outside read answer");

  chk_ctrl_write_back: assert property (
    wrHit ##1 rdHit
      |=> regRdData[CTRL_W-1:0] == $past(regWrData[CTRL_W-1:0], 2))
    else $error("control field not written");

  chk_event_follows_core: assert property (
    ##2 1'b1 |=> state_reg.generalEventFlag == ($past(otgBusEvent, 3)
                 && $past(state_reg.ctrl[GENERAL_EVENT_IRQ_BIT])))
    else $error("general flag does not follow core event");

  chk_resume_needs_suspend: assert property (
    !otgSuspended [*3] |=> !state_reg.resumeFlag)
    else $error("resume flag set outside suspend");

  chk_activity_sticky: assert property (
    otgBusActivity ##3 1'b1 |-> state_reg.activityStatus)
    else $error("activity not captured");

  chk_activity_clear: assert property (
    activityClearWrite |=> !state_reg.activityStatus)
    else $error("activity bit not cleared by write");

  chk_activity_hold: assert property (
    state_reg.activityStatus && !wrHit |=> state_reg.activityStatus)
    else $error("activity bit dropped without clear");

  chk_id_override: assert property (
    state_reg.ctrl[ID_OVERRIDE_ENABLE_BIT]
      |=> otgId == $past(state_reg.ctrl[ID_OVERRIDE_VALUE_BIT]))
    else $error("override id not presented");

  chk_id_phy_pass: assert property (
    !state_reg.ctrl[ID_OVERRIDE_ENABLE_BIT]
      && state_reg.ctrl[PHY_ID_MONITOR_BIT]
      |=> otgId == $past(state_reg.syncSecond[S_PHY_ID]))
    else $error("phy id not passed");

  chk_id_monitor_off: assert property (
    !state_reg.ctrl[ID_OVERRIDE_ENABLE_BIT]
      && !state_reg.ctrl[PHY_ID_MONITOR_BIT] |=> otgId == ID_DEFAULT_LEVEL)
    else $error("id not defaulted with monitor off");

  chk_vbus_gate: assert property (
    !state_reg.ctrl[VBUS_VALID_MONITOR_BIT] |=> !otgVbusValid)
    else $error("vbus valid passed while disabled");

  chk_comparator_pass: assert property (
    (&state_reg.ctrl[A_SESSION_MONITOR_BIT:SESSION_END_MONITOR_BIT])
      |=> otgASessionValid == $past(state_reg.syncSecond[S_A_SESSION])
          && otgBSessionValid == $past(state_reg.syncSecond[S_B_SESSION])
          && otgSessionEnd == $past(state_reg.syncSecond[S_SESSION_END]))
    else $error("session comparators not passed");

  chk_session_gate: assert property (
    !state_reg.ctrl[A_SESSION_MONITOR_BIT]
      && !state_reg.ctrl[B_SESSION_MONITOR_BIT]
      && !state_reg.ctrl[SESSION_END_MONITOR_BIT]
      |=> !otgASessionValid && !otgBSessionValid && !otgSessionEnd)
    else $error("session comparator passed while disabled");

  chk_irq_masked: assert property (
    state_reg.ctrl[2:0] == 3'h0 |-> !irq)
    else $error("interrupt with all enables off");

  chk_irq_activity: assert property (
    state_reg.activityStatus && state_reg.ctrl[ACTIVITY_IRQ_BIT] |-> irq)
    else $error("activity interrupt missing");

  chk_irq_event: assert property (
    state_reg.generalEventFlag && state_reg.ctrl[GENERAL_EVENT_IRQ_BIT]
      |-> irq)
    else $error("general event interrupt missing");

  chk_irq_resume: assert property (
    state_reg.resumeFlag && state_reg.ctrl[RESUME_IRQ_BIT] |-> irq)
    else $error("resume interrupt missing");

  chk_reset_value: assert property (
    disable iff (1'b0)
    $fell(srst) ##0 rdHit |=> regRdData == CTRL_STATUS_RESET)
    else $error("reset value wrong");

  chk_vbus_pass: assert property (
    state_reg.ctrl[VBUS_VALID_MONITOR_BIT]
      |=> otgVbusValid == $past(state_reg.syncSecond[S_VBUS_VALID]))
    else $error("vbus valid not passed");

  chk_asess_pass: assert property (
    state_reg.ctrl[A_SESSION_MONITOR_BIT]
      |=> otgASessionValid == $past(state_reg.syncSecond[S_A_SESSION]))
    else $error("a-session comparator not passed");

  chk_bsess_pass: assert property (
    state_reg.ctrl[B_SESSION_MONITOR_BIT]
      |=> otgBSessionValid == $past(state_reg.syncSecond[S_B_SESSION]))
    else $error("b-session comparator not passed");

  chk_send_pass: assert property (
    state_reg.ctrl[SESSION_END_MONITOR_BIT]
      |=> otgSessionEnd == $past(state_reg.syncSecond[S_SESSION_END]))
    else $error("session end comparator not passed");

  chk_resume_capture: assert property (
    resumeSeen |-> ##3 state_reg.resumeFlag)
    else $error("resume while suspended not flagged");

  chk_event_gated: assert property (
    !state_reg.ctrl[GENERAL_EVENT_IRQ_BIT] |=> !state_reg.generalEventFlag)
    else $error("general flag set with its enable off");

  chk_irq_no_flags: assert property (
    !state_reg.generalEventFlag && !state_reg.resumeFlag
      && !state_reg.activityStatus |-> !irq)
    else $error("interrupt without a flag");

  chk_activity_keep: assert property (
    state_reg.activityStatus && wrHit
      && !regWrData[ACTIVITY_STATUS_BIT] |=> state_reg.activityStatus)
    else $error("activity bit cleared by writing zero");

  chk_ctrl_stable: assert property (
    !wrHit |=> $stable(state_reg.ctrl))
    else $error("control field changed without a write");

  chk_reset_flags: assert property (
    disable iff (1'b0)
    srst |=> state_reg.activityStatus && !state_reg.generalEventFlag
             && !state_reg.resumeFlag)
    else $error("flag reset values wrong");

  chk_reset_outputs: assert property (
    disable iff (1'b0)
    srst |=> otgId == ID_DEFAULT_LEVEL && !otgVbusValid && !irq
             && regRdData == '0)
    else $error("outputs wrong after reset");

endmodule

`default_nettype wire

// ---- rtl/usb_wrapper_pkg.sv ----
package usb_wrapper_pkg;

  // register port
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_STATUS_ADDR = 8'h00;

  // field positions of usb_wrapper_control_status
  localparam int unsigned GENERAL_EVENT_FLAG_BIT   = 26;
  localparam int unsigned RESUME_FLAG_BIT          = 25;
  localparam int unsigned ACTIVITY_STATUS_BIT      = 24;
  localparam int unsigned RESERVED_ONE_BIT         = 15;
  localparam int unsigned ID_OVERRIDE_ENABLE_BIT   = 9;
  localparam int unsigned ID_OVERRIDE_VALUE_BIT    = 8;
  localparam int unsigned PHY_ID_MONITOR_BIT       = 7;
  localparam int unsigned VBUS_VALID_MONITOR_BIT   = 6;
  localparam int unsigned A_SESSION_MONITOR_BIT    = 5;
  localparam int unsigned B_SESSION_MONITOR_BIT    = 4;
  localparam int unsigned SESSION_END_MONITOR_BIT  = 3;
  localparam int unsigned GENERAL_EVENT_IRQ_BIT    = 2;
  localparam int unsigned RESUME_IRQ_BIT           = 1;
  localparam int unsigned ACTIVITY_IRQ_BIT         = 0;

  // writable control field occupies bits 9..0
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // hardware flags reset values
  localparam logic GENERAL_EVENT_RESET = 1'b0;
  localparam logic RESUME_RESET        = 1'b0;
  localparam logic ACTIVITY_RESET      = 1'b1;

  // value of the whole word after reset
  localparam logic [DATA_W-1:0] CTRL_STATUS_RESET = 32'h0100_8000;

  // mask of bits that ever read as one
  localparam logic [DATA_W-1:0] IMPLEMENTED_MASK = 32'h0700_83FF;

  // id level presented while phy monitoring and id override are both off (b-device default)
  localparam logic ID_DEFAULT_LEVEL = 1'b1;

  // input synchroniser slots
  localparam int unsigned SYNC_W        = 9;
  localparam int unsigned S_OTG_EVENT   = 0;
  localparam int unsigned S_RESUME_DET  = 1;
  localparam int unsigned S_SUSPENDED   = 2;
  localparam int unsigned S_ACTIVITY    = 3;
  localparam int unsigned S_PHY_ID      = 4;
  localparam int unsigned S_VBUS_VALID  = 5;
  localparam int unsigned S_A_SESSION   = 6;
  localparam int unsigned S_B_SESSION   = 7;
  localparam int unsigned S_SESSION_END = 8;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 9'h000;

  // synchroniser depth; the checks do not reference it
  localparam int unsigned SYNC_LAT = 2;

endpackage

// ---- test/usb_clock_reset_wrapper_ctrl_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module usb_clock_reset_wrapper_ctrl_test;
  import usb_wrapper_pkg::*;

  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic        irq;
  logic [8:0]  lineCmd = 9'h000;
  logic        evt, res, sus, act, pId, pVb, pAs, pBs, pSe;
  logic        oId, oVb, oAs, oBs, oSe;
  logic [31:0] v;
  int          nFail = 0;
  int          nTests = 0;

  // row: control bits, phy levels {se,bs,as,vb,id}, expected otg lines
  localparam logic [19:0] ROWS [12] = '{
    {10'h000, 5'h1F, 5'h01}, {10'h0F8, 5'h1F, 5'h1F},
    {10'h0F8, 5'h0A, 5'h0A}, {10'h080, 5'h1C, 5'h00},
    {10'h040, 5'h02, 5'h03}, {10'h020, 5'h04, 5'h05},
    {10'h010, 5'h08, 5'h09}, {10'h008, 5'h10, 5'h11},
    {10'h200, 5'h01, 5'h00}, {10'h300, 5'h00, 5'h01},
    {10'h380, 5'h1E, 5'h01}, {10'h007, 5'h1F, 5'h01}};

  always #50 clk = ~clk;

  usb_core_phy_model u_usb_core_phy_model (
    .clk(clk), .lineCmd(lineCmd), .otgBusEvent(evt),
    .otgResumeDetect(res), .otgSuspended(sus), .otgBusActivity(act),
    .phyId(pId), .phyVbusValid(pVb), .phyASessionValid(pAs),
    .phyBSessionValid(pBs), .phySessionEnd(pSe));

  usb_clock_reset_wrapper_ctrl u_usb_clock_reset_wrapper_ctrl (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .irq(irq), .otgBusEvent(evt), .otgResumeDetect(res),
    .otgSuspended(sus), .otgBusActivity(act), .phyId(pId),
    .phyVbusValid(pVb), .phyASessionValid(pAs), .phyBSessionValid(pBs),
    .phySessionEnd(pSe), .otgId(oId), .otgVbusValid(oVb),
    .otgASessionValid(oAs), .otgBSessionValid(oBs), .otgSessionEnd(oSe));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      nFail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask

  // read data stands one cycle only, so the idle value is checked too
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
    @(posedge clk);
    #1 chk("rdIdle", regRdData, 32'h0);
  endtask

  // drive the far side at an edge, then wait out the synchronisers
  task automatic lines(input logic [8:0] c);
    @(posedge clk);
    lineCmd <= c;
    cyc(6);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(5000);
    nFail++;
    stop_test();
  end

  initial
  begin
    cyc(4);
    srst <= 1'b0;
    rd(8'h00, v);
    chk("resetWord", v, 32'h0100_8000);
    chk("resetIrq", {31'h0, irq}, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, v);
    chk("unmapped", v, 32'h0);
    rd(8'h00, v);
    chk("unmappedWr", v, 32'h0100_8000);
    wr(8'h00, 32'h0100_0000);
    rd(8'h00, v);
    chk("actClear", v, 32'h0000_8000);
    $display("reset and map done");
    // junk in unimplemented and read-only bits must not stick
    foreach (ROWS[i])
    begin
      @(posedge clk);
      lineCmd <= {ROWS[i][9:5], 4'h0};
      wr(8'h00, {22'h0, ROWS[i][19:10]} | 32'hFEFF_7C00);
      cyc(6);
      chk("otgLines", {27'h0, oSe, oBs, oAs, oVb, oId},
          {27'h0, ROWS[i][4:0]});
      rd(8'h00, v);
      chk("ctrlWord", v, {22'h0, ROWS[i][19:10]} | 32'h8000);
      chk("rowIrq", {31'h0, irq}, 32'h0);
    end
    $display("table done");
    wr(8'h00, 32'h4);
    lines(9'h001);
    rd(8'h00, v);
    chk("evtSet", v, 32'h0400_8004);
    chk("evtIrq", {31'h0, irq}, 32'h1);
    wr(8'h00, 32'h0);
    cyc(2);
    chk("evtMasked", {31'h0, irq}, 32'h0);
    rd(8'h00, v);
    chk("evtNoEn", v, 32'h0000_8000);
    wr(8'h00, 32'h4);
    lines(9'h000);
    rd(8'h00, v);
    chk("evtGone", v, 32'h0000_8004);
    chk("evtIrqOff", {31'h0, irq}, 32'h0);
    $display("event done");
    wr(8'h00, 32'h2);
    lines(9'h002);
    rd(8'h00, v);
    chk("resNoSusp", v, 32'h0000_8002);
    chk("resNoIrq", {31'h0, irq}, 32'h0);
    lines(9'h006);
    rd(8'h00, v);
    chk("resSet", v, 32'h0200_8002);
    chk("resIrq", {31'h0, irq}, 32'h1);
    lines(9'h000);
    $display("resume done");
    wr(8'h00, 32'h1);
    @(posedge clk);
    lineCmd <= 9'h008;
    @(posedge clk);
    lineCmd <= 9'h000;
    cyc(6);
    rd(8'h00, v);
    chk("actSticky", v, 32'h0100_8001);
    chk("actIrq", {31'h0, irq}, 32'h1);
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, v);
    chk("actWrZero", v, 32'h0100_8001);
    wr(8'h00, 32'h0100_0000);
    rd(8'h00, v);
    chk("actW1c", v, 32'h0000_8000);
    @(posedge clk);
    lineCmd <= 9'h008;
    @(posedge clk);
    lineCmd <= 9'h000;
    cyc(6);
    rd(8'h00, v);
    chk("actNoEn", v, 32'h0100_8000);
    chk("actMasked", {31'h0, irq}, 32'h0);
    $display("activity done");
    // write then read with no gap sees the new control value
    @(posedge clk);
    regWrite  <= 1'b1;
    regAddr   <= 8'h00;
    regWrData <= 32'h0000_0155;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("b2bRead", regRdData, 32'h0100_8155);
    @(posedge clk);
    srst <= 1'b1;
    cyc(3);
    // read issued in the first cycle after reset drops
    srst    <= 1'b0;
    regRead <= 1'b1;
    regAddr <= 8'h00;
    @(posedge clk);
    regRead <= 1'b0;
    #1 v = regRdData;
    chk("reReset", v, 32'h0100_8000);
    chk("reResetId", {31'h0, oId}, 32'h1);
    $display("back to back and reset done");
    stop_test();
  end
endmodule

`default_nettype wire

// ---- test/usb_core_phy_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module usb_core_phy_model
  import usb_wrapper_pkg::*;
(
  // clock
  input  wire logic                               clk,
  // line levels requested by the bench, one slot each
  input  wire logic [usb_wrapper_pkg::SYNC_W-1:0] lineCmd,
  // controller core levels
  output logic                                    otgBusEvent,
  output logic                                    otgResumeDetect,
  output logic                                    otgSuspended,
  output logic                                    otgBusActivity,
  // phy and comparator levels
  output logic                                    phyId,
  output logic                                    phyVbusValid,
  output logic                                    phyASessionValid,
  output logic                                    phyBSessionValid,
  output logic                                    phySessionEnd
);
  import usb_wrapper_pkg::*;

  // levels launch from the far side's own flops on the same clk, one cycle
  // after lineCmd changes, and then must pass the synchronisers
  initial
  begin
    {otgBusEvent, otgResumeDetect, otgSuspended, otgBusActivity} = 4'h0;
    {phyId, phyVbusValid, phyASessionValid} = 3'h0;
    {phyBSessionValid, phySessionEnd} = 2'h0;
  end

  always @(posedge clk)
  begin
    otgBusEvent      <= lineCmd[S_OTG_EVENT];
    otgResumeDetect  <= lineCmd[S_RESUME_DET];
    otgSuspended     <= lineCmd[S_SUSPENDED];
    otgBusActivity   <= lineCmd[S_ACTIVITY];
    phyId            <= lineCmd[S_PHY_ID];
    phyVbusValid     <= lineCmd[S_VBUS_VALID];
    phyASessionValid <= lineCmd[S_A_SESSION];
    phyBSessionValid <= lineCmd[S_B_SESSION];
    phySessionEnd    <= lineCmd[S_SESSION_END];
  end
endmodule

`default_nettype wire
